// ### shared/sbp_map.svh
`ifndef SBP_MAP_SVH
`define SBP_MAP_SVH

// ----------------------------------------
// access port widths
// ----------------------------------------
`define SBP_ADDR_W        4
`define SBP_DATA_W        8
`define SBP_RAM_AW        5
`define SBP_NUM_PORTS     2'h3
`define SBP_PAGE_BASE     4'h8

// ----------------------------------------
// register offsets (index on the access port)
// ----------------------------------------
`define SBP_REG_IDENT     4'h0
`define SBP_REG_RESET     4'h1
`define SBP_REG_COUNTS    4'h2
`define SBP_REG_SPEED     4'h3
`define SBP_REG_SELFID    4'h4
`define SBP_REG_EVENTS    4'h5
`define SBP_REG_SELECT    4'h7
`define SBP_REG_PSTAT0    4'h8
`define SBP_REG_PSTAT1    4'h9

// ----------------------------------------
// field positions
// ----------------------------------------
`define SBP_B_ROOT_HOLD   7
`define SBP_B_BUS_RESET   6
`define SBP_B_LINK_ACT    7
`define SBP_B_CONTENDER   6
`define SBP_B_RESUME      7
`define SBP_B_SHORT_RST   6
`define SBP_B_FAST_ARB    1
`define SBP_B_CONCAT      0
`define SBP_B_DISABLE     0
`define SBP_B_INT_EN      4
`define SBP_FLAG_LO       2
`define SBP_FLAG_HI       5

// ----------------------------------------
// reset values and fixed constants
// ----------------------------------------
`define SBP_RST_GAP       6'h3f
`define SBP_RST_LINK      1'h1
`define SBP_RST_PWR       3'h4
`define SBP_EXT_COUNT     4'h7
`define SBP_PORT_COUNT    3'h3
`define SBP_MAX_SPEED     3'h2
`define SBP_DELAY         4'h0

`endif

// ### shared/sbp_pkg.sv
package sbp_pkg;

	// ----------------------------------------
	// shared types
	// ----------------------------------------
	typedef logic [7:0] sbp_byte_t;

	// page selector codes
	typedef enum logic [2:0] {
		SBP_PAGE_PORT_STATUS = 3'h0,
		SBP_PAGE_VENDOR_ID   = 3'h1,
		SBP_PAGE_VENDOR_SPEC = 3'h7
	} sbp_page_e;

	// per-port status that raises a port change
	typedef struct packed {
		logic connected;
		logic bias;
		logic disabled;
		logic fault;
	} sbp_port_watch_s;

endpackage

// ### shared/sbp_ram_if.sv
`timescale 1ns/1ps
`include "sbp_map.svh"

interface sbp_ram_if;
	logic                    we;
	logic [`SBP_RAM_AW-1:0]  waddr;
	logic [`SBP_RAM_AW-1:0]  raddr;
	logic [7:0]              wdata;
	logic [7:0]              rdata;

	modport ctrl (output we, output waddr, output raddr, output wdata, input rdata);
	modport mem  (input we, input waddr, input raddr, input wdata, output rdata);
endinterface

// ### src/sbp_page_ram.sv
`timescale 1ns/1ps
`include "sbp_map.svh"

module sbp_page_ram (
	// clock
	input  wire logic i_core_clk,
	input  wire logic i_ce,
	// memory port
	sbp_ram_if.mem    m
);
	// ----------------------------------------
	// vendor page storage, eight bytes per port
	// ----------------------------------------
	logic [7:0] mem_q [0:23];
	logic [7:0] next_rdata;

	// read data comes out of a register
	always_comb begin
		next_rdata = m.rdata;
		if (i_ce) begin
			next_rdata = mem_q[m.raddr];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_ce && m.we) begin
			mem_q[m.waddr] <= m.wdata;
		end
		m.rdata <= next_rdata;
	end
endmodule

// ### src/sbp_sticky_flags.sv
`timescale 1ns/1ps

module sbp_sticky_flags (
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rstn,
	input  wire logic       i_ce,
	// events and clears
	input  wire logic [3:0] i_set,
	input  wire logic [3:0] i_clr,
	// flag state
	output logic      [3:0] o_flags
);
	logic [3:0] next_flags;

	// set beats clear in the same cycle
	always_comb begin
		next_flags = o_flags;
		if (i_ce) begin
			next_flags = (o_flags & ~i_clr) | i_set;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			o_flags <= 4'h0;
		end else begin
			o_flags <= next_flags;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	flag_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && (i_clr & ~i_set) != 4'h0 |=> (o_flags & $past(i_clr & ~i_set)) == 4'h0)
		else $error("cleared flag still set");
	flag_set_wins_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && i_set != 4'h0 |=> (o_flags & $past(i_set)) == $past(i_set))
		else $error("flag event lost");
	flag_zero_keep_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && i_clr == 4'h0 |=> (o_flags & $past(o_flags)) == $past(o_flags))
		else $error("flag dropped without clear");
endmodule

// ### src/sbp_phy_regs.sv
// Functional notes
// - clearable flags drop on a written one; a written zero leaves them
// - node number shows as a six-bit read-only field
// - cable power bit reads one while supply is above nominal
// - root bit reads one while this node is root
// - root hold bit, zero at reset, asks for root at next bus reset
// - writing one to initiate bus reset starts a bus reset
// - six-bit gap setting holds its value and resets to all ones
// - extended count reads seven, port count three, repeat latency zero
// - speed capability reads the S400 code
// - link active and contender flags feed the self-ID packet
// - three-bit repeat jitter field is writable, resets to zero
// - power class, reset 100b, feeds the self-ID power field
// - resume indicator goes to one when a resume happens
// - writing one to short reset request launches an arbitrated short reset
// - topology cycle flag sets when ports form a loop
// - supply failure flag sets when cable power drops below nominal
// - arbitration expiry flag sets on arbitration state timeout
// - port change flag sets on watched status change with port enable set
// - fast arbitration enable turns on accelerated arbitration
// - concatenation enable allows multi-speed back-to-back packets
// - page and port selectors open port status or vendor pages; the vendor id page reads zero and ignores writes
// - vendor page acts as eight bytes of read/write storage
`timescale 1ns/1ps
`include "sbp_map.svh"

module sbp_phy_regs (
	// clock, reset, enable
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rstn,
	input  wire logic                   i_ce,
	// register access from the link
	input  wire logic [`SBP_ADDR_W-1:0] i_acc_addr,
	input  wire logic [7:0]             i_acc_wdata,
	input  wire logic                   i_acc_wr,
	input  wire logic                   i_acc_rd,
	output logic      [7:0]             o_acc_rdata,
	output logic                        o_acc_rvalid,
	// node status from the bus logic
	input  wire logic [5:0]             i_node_number,
	input  wire logic                   i_is_root,
	input  wire logic                   i_cable_power_ok,
	input  wire logic                   i_loop_detect,
	input  wire logic                   i_arb_timeout,
	input  wire logic                   i_resume_event,
	// port status
	input  wire logic [2:0]             i_port_connected,
	input  wire logic [2:0]             i_port_bias,
	input  wire logic [2:0]             i_port_fault,
	// controls to the bus logic
	output logic                        o_bus_reset_req,
	output logic                        o_short_reset_req,
	output logic                        o_root_hold,
	output logic      [5:0]             o_gap_count,
	output logic                        o_link_active,
	output logic                        o_contender,
	output logic      [2:0]             o_power_class,
	output logic      [2:0]             o_repeat_jitter,
	output logic                        o_fast_arb_en,
	output logic                        o_concat_en,
	output logic      [2:0]             o_port_disable
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// vendor page byte index for a port and register
	function automatic logic [`SBP_RAM_AW-1:0] ram_index(input logic [3:0] port, input logic [2:0] r);
		ram_index = {port[1:0], r};
	endfunction

	// paged access targets a real port
	function automatic logic port_ok(input logic [3:0] port);
		port_ok = (port < {2'h0, `SBP_NUM_PORTS});
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic                  root_hold, next_root_hold;
	logic                  bus_reset, next_bus_reset;
	logic [5:0]            gap_count, next_gap_count;
	logic                  link_active, next_link_active;
	logic                  contender, next_contender;
	logic [2:0]            jitter, next_jitter;
	logic [2:0]            power_class, next_power_class;
	logic                  resume_ind, next_resume_ind;
	logic                  short_reset, next_short_reset;
	logic                  fast_arb, next_fast_arb;
	logic                  concat, next_concat;
	logic [2:0]            page_sel, next_page_sel;
	logic [3:0]            port_sel, next_port_sel;
	logic [2:0]            port_dis, next_port_dis;
	logic [2:0]            port_ie, next_port_ie;
	logic [2:0]            pwr_hist, next_pwr_hist;
	sbp_pkg::sbp_port_watch_s [2:0] watch_prev, next_watch, watch_cur;
	logic [7:0]            rd_stage, next_rd_stage, next_rdata, rd_mux;
	logic                  rd_pend, next_rd_pend, next_rvalid;
	logic                  rd_from_ram, next_rd_from_ram;

	logic                  wr_take, rd_take, paged, vendor_hit, port_evt, pwr_drop;
	logic [3:0]            flag_set, flag_clr, flags;

	sbp_ram_if             ram ();

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	// a write in the same cycle as a read takes precedence
	assign wr_take    = i_ce && i_acc_wr;
	assign rd_take    = i_ce && i_acc_rd && !i_acc_wr;
	assign paged      = (i_acc_addr >= `SBP_PAGE_BASE) && port_ok(port_sel);
	assign vendor_hit = paged && (page_sel == sbp_pkg::SBP_PAGE_VENDOR_SPEC);

	// vendor page storage port
	assign ram.we    = wr_take && vendor_hit;
	assign ram.waddr = ram_index(port_sel, i_acc_addr[2:0]);
	assign ram.wdata = i_acc_wdata;
	assign ram.raddr = ram_index(port_sel, i_acc_addr[2:0]);

	sbp_page_ram u_ram (
		.i_core_clk (i_core_clk),
		.i_ce       (i_ce),
		.m          (ram.ctrl)
	);

	// ----------------------------------------
	// events into the clearable flags
	// ----------------------------------------
	// cable power history, two samples to see a drop
	assign pwr_drop = pwr_hist[1] && !pwr_hist[0];

	always_comb begin
		port_evt = 1'b0;
		for (int p = 0; p < 3; p++) begin
			watch_cur[p] = '{connected: i_port_connected[p], bias: i_port_bias[p],
				disabled: port_dis[p], fault: i_port_fault[p]};
			if ((watch_cur[p] != watch_prev[p]) && port_ie[p]) begin
				port_evt = 1'b1;
			end
		end
	end

	// bit order matches the event register layout
	assign flag_set = {i_loop_detect, pwr_drop, i_arb_timeout, port_evt};
	assign flag_clr = (wr_take && i_acc_addr == `SBP_REG_EVENTS) ?
		i_acc_wdata[`SBP_FLAG_HI:`SBP_FLAG_LO] : 4'h0;

	sbp_sticky_flags u_flags (
		.i_core_clk (i_core_clk),
		.i_rstn     (i_rstn),
		.i_ce       (i_ce),
		.i_set      (flag_set),
		.i_clr      (flag_clr),
		.o_flags    (flags)
	);

	// ----------------------------------------
	// read data selection
	// ----------------------------------------
	always_comb begin
		rd_mux = 8'h00;
		if (i_acc_addr == `SBP_REG_IDENT) begin
			rd_mux = {i_node_number, i_is_root, i_cable_power_ok};
		end else if (i_acc_addr == `SBP_REG_RESET) begin
			rd_mux = {root_hold, bus_reset, gap_count};
		end else if (i_acc_addr == `SBP_REG_COUNTS) begin
			rd_mux = {`SBP_EXT_COUNT, 1'b0, `SBP_PORT_COUNT};
		end else if (i_acc_addr == `SBP_REG_SPEED) begin
			rd_mux = {`SBP_MAX_SPEED, 1'b0, `SBP_DELAY};
		end else if (i_acc_addr == `SBP_REG_SELFID) begin
			rd_mux = {link_active, contender, jitter, power_class};
		end else if (i_acc_addr == `SBP_REG_EVENTS) begin
			rd_mux = {resume_ind, short_reset, flags, fast_arb, concat};
		end else if (i_acc_addr == `SBP_REG_SELECT) begin
			rd_mux = {page_sel, 1'b0, port_sel};
		end else if (paged && page_sel == sbp_pkg::SBP_PAGE_PORT_STATUS) begin
			if (i_acc_addr == `SBP_REG_PSTAT0) begin
				rd_mux = {5'h00, i_port_connected[port_sel[1:0]], i_port_bias[port_sel[1:0]],
					port_dis[port_sel[1:0]]};
			end else if (i_acc_addr == `SBP_REG_PSTAT1) begin
				rd_mux = {3'h0, port_ie[port_sel[1:0]], i_port_fault[port_sel[1:0]], 3'h0};
			end
		end
	end

	// ----------------------------------------
	// register next values
	// ----------------------------------------
	always_comb begin
		next_root_hold   = root_hold;
		next_bus_reset   = bus_reset && !i_ce;                                     // pulse frozen with ce low
		next_gap_count   = gap_count;
		next_link_active = link_active;
		next_contender   = contender;
		next_jitter      = jitter;
		next_power_class = power_class;
		next_resume_ind  = resume_ind;
		next_short_reset = short_reset && !i_ce;
		next_fast_arb    = fast_arb;
		next_concat      = concat;
		next_page_sel    = page_sel;
		next_port_sel    = port_sel;
		next_port_dis    = port_dis;
		next_port_ie     = port_ie;
		next_pwr_hist    = pwr_hist;
		next_watch       = watch_prev;
		if (i_ce) begin
			next_pwr_hist = {pwr_hist[1:0], i_cable_power_ok};
			next_watch    = watch_cur;
		end
		// writes to read-only fields fall through untouched
		if (wr_take) begin
			if (i_acc_addr == `SBP_REG_RESET) begin
				next_root_hold = i_acc_wdata[`SBP_B_ROOT_HOLD];
				next_bus_reset = i_acc_wdata[`SBP_B_BUS_RESET];
				next_gap_count = i_acc_wdata[5:0];
			end else if (i_acc_addr == `SBP_REG_SELFID) begin
				next_link_active = i_acc_wdata[`SBP_B_LINK_ACT];
				next_contender   = i_acc_wdata[`SBP_B_CONTENDER];
				next_jitter      = i_acc_wdata[5:3];
				next_power_class = i_acc_wdata[2:0];
			end else if (i_acc_addr == `SBP_REG_EVENTS) begin
				next_resume_ind  = i_acc_wdata[`SBP_B_RESUME];
				next_short_reset = i_acc_wdata[`SBP_B_SHORT_RST];
				next_fast_arb    = i_acc_wdata[`SBP_B_FAST_ARB];
				next_concat      = i_acc_wdata[`SBP_B_CONCAT];
			end else if (i_acc_addr == `SBP_REG_SELECT) begin
				next_page_sel = i_acc_wdata[7:5];
				next_port_sel = i_acc_wdata[3:0];
			end else if (paged && page_sel == sbp_pkg::SBP_PAGE_PORT_STATUS) begin
				if (i_acc_addr == `SBP_REG_PSTAT0) begin
					next_port_dis[port_sel[1:0]] = i_acc_wdata[`SBP_B_DISABLE];
				end else if (i_acc_addr == `SBP_REG_PSTAT1) begin
					next_port_ie[port_sel[1:0]] = i_acc_wdata[`SBP_B_INT_EN];
				end
			end
		end
		// a resume in the same cycle as a write still shows
		if (i_ce && i_resume_event) begin
			next_resume_ind = 1'b1;
		end
	end

	// ----------------------------------------
	// read pipeline next values
	// ----------------------------------------
	always_comb begin
		next_rd_stage    = rd_stage;
		next_rd_pend     = rd_pend;
		next_rd_from_ram = rd_from_ram;
		next_rdata       = o_acc_rdata;
		next_rvalid      = o_acc_rvalid;
		if (i_ce) begin
			next_rd_pend     = rd_take;
			next_rd_stage    = rd_mux;
			next_rd_from_ram = vendor_hit;
			next_rvalid      = rd_pend;
			if (rd_pend) begin
				next_rdata = rd_from_ram ? ram.rdata : rd_stage;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rstn) begin
			root_hold    <= 1'b0;
			bus_reset    <= 1'b0;
			gap_count    <= `SBP_RST_GAP;
			link_active  <= `SBP_RST_LINK;
			contender    <= 1'b0;
			jitter       <= 3'h0;
			power_class  <= `SBP_RST_PWR;
			resume_ind   <= 1'b0;
			short_reset  <= 1'b0;
			fast_arb     <= 1'b0;
			concat       <= 1'b0;
			page_sel     <= 3'h0;
			port_sel     <= 4'h0;
			port_dis     <= 3'h0;
			port_ie      <= 3'h0;
			pwr_hist     <= 3'h0;
			watch_prev   <= '0;
			rd_stage     <= 8'h00;
			rd_pend      <= 1'b0;
			rd_from_ram  <= 1'b0;
			o_acc_rdata  <= 8'h00;
			o_acc_rvalid <= 1'b0;
		end else begin
			root_hold    <= next_root_hold;
			bus_reset    <= next_bus_reset;
			gap_count    <= next_gap_count;
			link_active  <= next_link_active;
			contender    <= next_contender;
			jitter       <= next_jitter;
			power_class  <= next_power_class;
			resume_ind   <= next_resume_ind;
			short_reset  <= next_short_reset;
			fast_arb     <= next_fast_arb;
			concat       <= next_concat;
			page_sel     <= next_page_sel;
			port_sel     <= next_port_sel;
			port_dis     <= next_port_dis;
			port_ie      <= next_port_ie;
			pwr_hist     <= next_pwr_hist;
			watch_prev   <= next_watch;
			rd_stage     <= next_rd_stage;
			rd_pend      <= next_rd_pend;
			rd_from_ram  <= next_rd_from_ram;
			o_acc_rdata  <= next_rdata;
			o_acc_rvalid <= next_rvalid;
		end
	end

	// outputs straight from the registers
	assign o_bus_reset_req   = bus_reset;
	assign o_short_reset_req = short_reset;
	assign o_root_hold       = root_hold;
	assign o_gap_count       = gap_count;
	assign o_link_active     = link_active;
	assign o_contender       = contender;
	assign o_power_class     = power_class;
	assign o_repeat_jitter   = jitter;
	assign o_fast_arb_en     = fast_arb;
	assign o_concat_en       = concat;
	assign o_port_disable    = port_dis;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	bus_reset_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		wr_take && i_acc_addr == `SBP_REG_RESET && i_acc_wdata[`SBP_B_BUS_RESET]
		|=> o_bus_reset_req ##1 (!o_bus_reset_req || !$past(i_ce)))
		else $error("bus reset request not a single pulse");
	short_reset_pulse_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		wr_take && i_acc_addr == `SBP_REG_EVENTS && i_acc_wdata[`SBP_B_SHORT_RST]
		|=> o_short_reset_req ##1 (!o_short_reset_req || !$past(i_ce)))
		else $error("short reset request not a single pulse");
	gap_reset_val_a: assert property (@(posedge i_core_clk)
		!i_rstn |=> o_gap_count == `SBP_RST_GAP && o_power_class == `SBP_RST_PWR && o_link_active)
		else $error("reset values wrong");
	const_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		rd_take && i_acc_addr == `SBP_REG_COUNTS ##1 i_ce
		|=> o_acc_rvalid && o_acc_rdata == {`SBP_EXT_COUNT, 1'b0, `SBP_PORT_COUNT})
		else $error("count constants read wrong");
	node_read_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		rd_take && i_acc_addr == `SBP_REG_IDENT ##1 i_ce
		|=> o_acc_rdata[7:2] == $past(i_node_number, 2))
		else $error("node number read wrong");
	pwr_fail_flag_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && pwr_hist[0] && !i_cable_power_ok ##1 i_ce |=> flags[2])
		else $error("supply failure not flagged");
	port_change_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && (watch_cur[0] != watch_prev[0]) && !port_ie[0] && !port_ie[1] && !port_ie[2]
		|=> !flags[0] || $past(flags[0]))
		else $error("port change flagged while disabled");
	root_hold_write_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		wr_take && i_acc_addr == `SBP_REG_RESET |=> o_root_hold == $past(i_acc_wdata[`SBP_B_ROOT_HOLD]))
		else $error("root hold not written");
	ro_write_ignored_a: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		wr_take && i_acc_addr == `SBP_REG_IDENT |=> $stable(o_gap_count) && $stable(o_root_hold))
		else $error("read-only write disturbed state");
endmodule

// ### verification/sbp_link_model.sv
`timescale 1ns/1ps

module sbp_link_model (
	// clock
	input  wire logic       i_core_clk,
	// register access port
	output logic      [3:0] o_addr,
	output logic      [7:0] o_wdata,
	output logic            o_wr,
	output logic            o_rd,
	input  wire logic [7:0] i_rdata,
	input  wire logic       i_rvalid
);
	// idle bus at time zero
	initial begin
		o_addr  = 4'h0;
		o_wdata = 8'h00;
		o_wr    = 1'b0;
		o_rd    = 1'b0;
	end

	// one write strobe, entered just after an edge
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		o_addr  <= a;
		o_wdata <= d;
		o_wr    <= 1'b1;
		@(posedge i_core_clk);
		o_wr    <= 1'b0;
		o_wdata <= ~d; // released data never shows stale value
		@(posedge i_core_clk);
	endtask

	// one read strobe, answer awaited a bounded number of edges
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		d = 8'hxx;
		o_addr <= a;
		o_rd   <= 1'b1;
		@(posedge i_core_clk);
		o_rd   <= 1'b0;
		repeat (3) begin
			@(posedge i_core_clk);
			if (i_rvalid === 1'b1)
				d = i_rdata;
		end
	endtask
endmodule

// ### verification/serial_bus_phy_register_file_tb.sv
`timescale 1ns/1ps

module serial_bus_phy_register_file_tb;
	logic       clk, rstn, ce, wr, rd, rv, root, cpw, lp, ato, res, brq, srq, rh, la, ct, fa, cc;
	logic [3:0] addr;
	logic [7:0] wd, rdat, v;
	logic [5:0] node, gap;
	logic [2:0] pcon, pb, pf, pc, jit, pdis;
	int         n_fail = 0, cmp_count = 0, n_br = 0, n_sr = 0, cyc = 0;

	sbp_phy_regs uut (.i_core_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_acc_addr(addr), .i_acc_wdata(wd),
		.i_acc_wr(wr), .i_acc_rd(rd), .o_acc_rdata(rdat), .o_acc_rvalid(rv), .i_node_number(node),
		.i_is_root(root), .i_cable_power_ok(cpw), .i_loop_detect(lp), .i_arb_timeout(ato),
		.i_resume_event(res), .i_port_connected(pcon), .i_port_bias(pb), .i_port_fault(pf),
		.o_bus_reset_req(brq), .o_short_reset_req(srq), .o_root_hold(rh), .o_gap_count(gap),
		.o_link_active(la), .o_contender(ct), .o_power_class(pc), .o_repeat_jitter(jit),
		.o_fast_arb_en(fa), .o_concat_en(cc), .o_port_disable(pdis));
	sbp_link_model lnk (.i_core_clk(clk), .o_addr(addr), .o_wdata(wd), .o_wr(wr), .o_rd(rd),
		.i_rdata(rdat), .i_rvalid(rv));

	// clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// pulse counters and hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (brq === 1'b1)
			n_br <= n_br + 1;
		if (srq === 1'b1)
			n_sr <= n_sr + 1;
		if (cyc == 3000) begin
			n_fail = n_fail + 1;
			give_verdict();
		end
	end

	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
		lnk.rd(a, v);
		chk(exp, v);
	endtask

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// main sequence
	initial begin
		rstn = 1'b0;
		ce   = 1'b1;
		node = 6'h2a;
		root = 1'b1;
		cpw  = 1'b1;
		{lp, ato, res} = 3'h0;
		{pcon, pb, pf} = 9'h000;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rchk(4'h1, 8'h3f);
		rchk(4'h2, 8'h73);
		rchk(4'h3, 8'h40);
		rchk(4'h4, 8'h84);
		rchk(4'h5, 8'h00);
		rchk(4'h0, 8'hab);
		$display("test reset values done");
		lnk.wr(4'h0, 8'h00);
		lnk.wr(4'h2, 8'h00);
		root <= 1'b0;
		rchk(4'h0, 8'ha9);
		rchk(4'h2, 8'h73);
		$display("test read only done");
		lnk.wr(4'h1, 8'h95);
		rchk(4'h1, 8'h95);
		chk({rh, 1'b0, gap}, 8'h95);
		lnk.wr(4'h1, 8'hd5);
		rchk(4'h1, 8'h95);
		chk(8'(n_br), 8'h01);
		ce <= 1'b0;
		lnk.wr(4'h1, 8'h2a);
		ce <= 1'b1;
		rchk(4'h1, 8'h95);
		lnk.wr(4'h4, 8'h5b);
		rchk(4'h4, 8'h5b);
		chk({la, ct, jit, pc}, 8'h5b);
		$display("test writable fields done");
		{lp, ato, res, cpw} <= 4'he;
		@(posedge clk);
		{lp, ato, res} <= 3'h0;
		repeat (3) @(posedge clk);
		rchk(4'h5, 8'hb8);
		rchk(4'h0, 8'ha8);
		lnk.wr(4'h5, 8'h28);
		rchk(4'h5, 8'h10);
		lnk.wr(4'h5, 8'h13);
		rchk(4'h5, 8'h03);
		chk({6'h00, fa, cc}, 8'h03);
		lnk.wr(4'h5, 8'h43);
		rchk(4'h5, 8'h03);
		chk(8'(n_sr), 8'h01);
		$display("test flags done");
		pb <= 3'b001;
		repeat (3) @(posedge clk);
		rchk(4'h5, 8'h03);
		lnk.wr(4'h7, 8'h01);
		lnk.wr(4'h9, 8'h10);
		pcon <= 3'b010;
		repeat (3) @(posedge clk);
		rchk(4'h5, 8'h07);
		rchk(4'h8, 8'h04);
		rchk(4'h9, 8'h10);
		lnk.wr(4'h8, 8'h01);
		rchk(4'h8, 8'h05);
		chk({5'h00, pdis}, 8'h02);
		$display("test port status done");
		lnk.wr(4'h7, 8'he2);
		for (int i = 0; i < 8; i++)
			lnk.wr(4'(8 + i), 8'(8'h30 + i));
		lnk.wr(4'h7, 8'he1);
		lnk.wr(4'h8, 8'h99);
		lnk.wr(4'h7, 8'he2);
		for (int i = 0; i < 8; i++)
			rchk(4'(8 + i), 8'(8'h30 + i));
		lnk.wr(4'h7, 8'h21);
		lnk.wr(4'h8, 8'h55);
		rchk(4'h8, 8'h00);
		$display("test paged storage done");
		give_verdict();
	end
endmodule
